// [blt_host_model.sv]
// Host model issuing byte register cycles on the mapped and indexed paths
module blt_host_model (
  input  wire logic                   clk,
  output      blt_pkg::blt_host_req_t host_req,
  input  wire blt_pkg::blt_host_rsp_t host_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial host_req = '0;
  // Released lines carry the inverse so a stale value never passes for a live one
  task automatic cyc(input logic w, input logic io, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    host_req <= '{wr: w, rd: !w, io: io, addr: a, wdata: d};
    @(posedge clk);
    host_req <= '{wr: 1'b0, rd: 1'b0, io: !io, addr: ~a, wdata: ~d};
  endtask : cyc
  task automatic rd(input logic io, input logic [6:0] a, output logic [7:0] d, output logic v);
    cyc(1'b0, io, a, 8'h00);
    #1;
    v = host_rsp.valid;
    d = host_rsp.data;
  endtask : rd
endmodule : blt_host_model

// [blt_param_regs.sv]
// Parameter register bank of the block-transfer engine
// Notes on behaviour
// R01: The width field is 13 bits and holds the width in bytes minus one.
// R02: Width bits 12:8 sit in the low five bits of the high byte, bits 7:0 in the low byte.
// R03: The height field is 11 bits and holds the scanline count minus one.
// R04: Height bits 10:8 sit in the low three bits of the high byte, bits 7:0 in the low byte.
// R05: Destination pitch is 13 bits, bits 12:8 in its high byte and 7:0 in its low byte.
// R06: Source pitch is 13 bits, bits 12:8 in its high byte and 7:0 in its low byte.
// R07: Destination start is a 22-bit byte address kept in three bytes as 21:16, 15:8, 7:0.
// R08: Source start is a 22-bit byte address kept in three bytes as 21:16, 15:8, 7:0.
// R09: For pattern copy the low bits of the lowest source start byte give the pattern offset.
// R10: Colour bytes used are 0 at 8 bpp, 0-1 at 16, 0-2 at 24 and 0-3 at 32 bpp.
// R11: Software must enable transparency at 24 bpp since no 24-bit background exists.
// R12: Foreground and background bytes feed both colour expansion and solid fill.
// R13: The two-bit expansion width in the mode register picks 8, 16, 24 or 32 bpp.
// R14: Stored values reach the engine unchanged at start; line address is start plus line times pitch.
module blt_param_regs #(
  parameter int unsigned PAT_OFS_W = 3
) (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire blt_pkg::blt_host_req_t         host_req,
  output      blt_pkg::blt_host_rsp_t         host_rsp,
  input  wire logic                           eng_busy,
  input  wire logic [blt_pkg::HEIGHT_W-1:0]   eng_line,
  output      blt_pkg::blt_params_t           eng_params,
  output      logic                           eng_start,
  output      logic                           eng_reset,
  output      logic                           eng_autostart,
  output      logic [31:0]                    fg_pixel,
  output      logic [31:0]                    bg_pixel,
  output      logic [blt_pkg::START_W-1:0]    dst_line_addr,
  output      logic [blt_pkg::START_W-1:0]    src_line_addr,
  output      logic [PAT_OFS_W-1:0]           pat_offset
);

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  if (PAT_OFS_W < 1 || PAT_OFS_W > 8) begin : g_bad_pat
    $error("PAT_OFS_W must lie in 1..8");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    blt_pkg::blt_params_t          cfg;
    logic [7:0]                    ctl;
    blt_pkg::blt_params_t          snap;
    blt_pkg::blt_host_rsp_t        rsp;
    logic                          start;
    logic [31:0]                   fg_pix;
    logic [31:0]                   bg_pix;
    logic [blt_pkg::START_W-1:0]   dline;
    logic [blt_pkg::START_W-1:0]   sline;
    logic [PAT_OFS_W-1:0]          pat;
  } blt_state_t;

  blt_state_t st_r;
  blt_state_t st_nxt;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Indexed accesses are folded onto the memory-mapped offsets so one decoder serves both
  function automatic logic [6:0] blt_offset(input logic io, input logic [6:0] a);
    logic [6:0] o;
    o = blt_pkg::OFS_NONE;
    if (!io) begin
      o = a;
    end else if (a == blt_pkg::IDX_BG0) begin
      o = blt_pkg::OFS_BG0;
    end else if (a == blt_pkg::IDX_FG0) begin
      o = blt_pkg::OFS_FG0;
    end else if (a >= blt_pkg::IDX_COL1 && a <= blt_pkg::IDX_COL7) begin
      // Odd indices are foreground, even ones background
      o = {4'h0, a[0], 2'(a[2:1] + 2'h1)};
    end else if (a == blt_pkg::IDX_START) begin
      o = blt_pkg::OFS_START;
    end else if (a >= blt_pkg::IDX_FIRST && a <= blt_pkg::IDX_LAST) begin
      o = 7'(a - blt_pkg::IDX_BASE);
    end
    return o;
  endfunction : blt_offset

  // Pick the colour bytes that the selected expansion width consults
  function automatic logic [31:0] blt_colour(input logic [31:0] b, input logic [1:0] w,
                                             input logic is_bg);
    logic [31:0] c;
    c = 32'h0;
    unique case (blt_pkg::blt_bpp_t'(w))
      blt_pkg::BPP8:  c = {24'h0, b[7:0]};
      blt_pkg::BPP16: c = {16'h0, b[15:0]};
      // There is no 24-bit background; zeroes must be transparent
      blt_pkg::BPP24: c = is_bg ? 32'h0 : {8'h0, b[23:0]};
      blt_pkg::BPP32: c = b;
    endcase
    return c;
  endfunction : blt_colour

  function automatic logic [blt_pkg::START_W-1:0] blt_line_addr(
    input logic [blt_pkg::START_W-1:0]  base,
    input logic [blt_pkg::PITCH_W-1:0]  pitch,
    input logic [blt_pkg::HEIGHT_W-1:0] line
  );
    logic [23:0] prod;
    logic [23:0] full;
    prod = 24'(pitch) * 24'(line);
    full = {2'h0, base} + prod;
    // Wraps within the 4 Mbyte space
    return full[blt_pkg::START_W-1:0];
  endfunction : blt_line_addr

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic [6:0] ofs;
  logic [7:0] wd;
  logic [7:0] rd;
  logic       go;

  always_comb begin
    st_nxt = st_r;
    ofs    = blt_offset(host_req.io, host_req.addr);
    wd     = host_req.wdata;
    rd     = 8'h00;
    go     = 1'b0;

    // Register writes
    if (host_req.wr) begin
      unique case (ofs)
        blt_pkg::OFS_BG0:   st_nxt.cfg.bg[7:0]       = wd;             // R12
        blt_pkg::OFS_BG1:   st_nxt.cfg.bg[15:8]      = wd;
        blt_pkg::OFS_BG2:   st_nxt.cfg.bg[23:16]     = wd;
        blt_pkg::OFS_BG3:   st_nxt.cfg.bg[31:24]     = wd;
        blt_pkg::OFS_FG0:   st_nxt.cfg.fg[7:0]       = wd;             // R12
        blt_pkg::OFS_FG1:   st_nxt.cfg.fg[15:8]      = wd;
        blt_pkg::OFS_FG2:   st_nxt.cfg.fg[23:16]     = wd;
        blt_pkg::OFS_FG3:   st_nxt.cfg.fg[31:24]     = wd;
        blt_pkg::OFS_WLO:   st_nxt.cfg.width[7:0]    = wd;             // R01
        blt_pkg::OFS_WHI:   st_nxt.cfg.width[12:8]   = wd[4:0];        // R02
        blt_pkg::OFS_HLO:   st_nxt.cfg.height[7:0]   = wd;             // R03
        blt_pkg::OFS_HHI:   st_nxt.cfg.height[10:8]  = wd[2:0];        // R04
        blt_pkg::OFS_DPLO:  st_nxt.cfg.dpitch[7:0]   = wd;             // R05
        blt_pkg::OFS_DPHI:  st_nxt.cfg.dpitch[12:8]  = wd[4:0];        // R05
        blt_pkg::OFS_SPLO:  st_nxt.cfg.spitch[7:0]   = wd;             // R06
        blt_pkg::OFS_SPHI:  st_nxt.cfg.spitch[12:8]  = wd[4:0];        // R06
        blt_pkg::OFS_DS0:   st_nxt.cfg.dstart[7:0]   = wd;             // R07
        blt_pkg::OFS_DS1:   st_nxt.cfg.dstart[15:8]  = wd;             // R07
        blt_pkg::OFS_DS2:   st_nxt.cfg.dstart[21:16] = wd[5:0];        // R07
        blt_pkg::OFS_SS0:   st_nxt.cfg.sstart[7:0]   = wd;             // R08
        blt_pkg::OFS_SS1:   st_nxt.cfg.sstart[15:8]  = wd;             // R08
        blt_pkg::OFS_SS2:   st_nxt.cfg.sstart[21:16] = wd[5:0];        // R08
        blt_pkg::OFS_CLIP:  st_nxt.cfg.clip          = wd;
        blt_pkg::OFS_MODE:  st_nxt.cfg.mode          = wd;             // R13
        blt_pkg::OFS_ROP:   st_nxt.cfg.rop           = wd;
        blt_pkg::OFS_MEXT:  st_nxt.cfg.mode_ext      = wd;
        blt_pkg::OFS_KEY0:  st_nxt.cfg.key[7:0]      = wd;
        blt_pkg::OFS_KEY1:  st_nxt.cfg.key[15:8]     = wd;
        blt_pkg::OFS_START: begin
          st_nxt.ctl = wd & blt_pkg::ST_WR_MASK;
          // A start request while the engine runs is dropped
          go         = wd[blt_pkg::ST_START] & ~eng_busy;
        end
        default: ;
      endcase
    end

    // Register reads; unused and reserved bits read as zero
    unique case (ofs)
      blt_pkg::OFS_BG0:   rd = st_r.cfg.bg[7:0];
      blt_pkg::OFS_BG1:   rd = st_r.cfg.bg[15:8];
      blt_pkg::OFS_BG2:   rd = st_r.cfg.bg[23:16];
      blt_pkg::OFS_BG3:   rd = st_r.cfg.bg[31:24];
      blt_pkg::OFS_FG0:   rd = st_r.cfg.fg[7:0];
      blt_pkg::OFS_FG1:   rd = st_r.cfg.fg[15:8];
      blt_pkg::OFS_FG2:   rd = st_r.cfg.fg[23:16];
      blt_pkg::OFS_FG3:   rd = st_r.cfg.fg[31:24];
      blt_pkg::OFS_WLO:   rd = st_r.cfg.width[7:0];
      blt_pkg::OFS_WHI:   rd = {3'h0, st_r.cfg.width[12:8]};           // R02
      blt_pkg::OFS_HLO:   rd = st_r.cfg.height[7:0];
      blt_pkg::OFS_HHI:   rd = {5'h0, st_r.cfg.height[10:8]};          // R04
      blt_pkg::OFS_DPLO:  rd = st_r.cfg.dpitch[7:0];
      blt_pkg::OFS_DPHI:  rd = {3'h0, st_r.cfg.dpitch[12:8]};          // R05
      blt_pkg::OFS_SPLO:  rd = st_r.cfg.spitch[7:0];
      blt_pkg::OFS_SPHI:  rd = {3'h0, st_r.cfg.spitch[12:8]};          // R06
      blt_pkg::OFS_DS0:   rd = st_r.cfg.dstart[7:0];
      blt_pkg::OFS_DS1:   rd = st_r.cfg.dstart[15:8];
      blt_pkg::OFS_DS2:   rd = {2'h0, st_r.cfg.dstart[21:16]};         // R07
      blt_pkg::OFS_SS0:   rd = st_r.cfg.sstart[7:0];
      blt_pkg::OFS_SS1:   rd = st_r.cfg.sstart[15:8];
      blt_pkg::OFS_SS2:   rd = {2'h0, st_r.cfg.sstart[21:16]};         // R08
      blt_pkg::OFS_CLIP:  rd = st_r.cfg.clip;
      blt_pkg::OFS_MODE:  rd = st_r.cfg.mode;
      blt_pkg::OFS_ROP:   rd = st_r.cfg.rop;
      blt_pkg::OFS_MEXT:  rd = st_r.cfg.mode_ext;
      blt_pkg::OFS_KEY0:  rd = st_r.cfg.key[7:0];
      blt_pkg::OFS_KEY1:  rd = st_r.cfg.key[15:8];
      blt_pkg::OFS_START: begin
        rd                   = st_r.ctl;
        rd[blt_pkg::ST_BUSY] = eng_busy | st_r.start;
      end
      default:            rd = 8'h00;
    endcase
    st_nxt.rsp.valid = host_req.rd;
    st_nxt.rsp.data  = host_req.rd ? rd : st_r.rsp.data;

    // Snapshot at start so later writes cannot disturb a running transfer
    st_nxt.start = go;
    if (go) begin
      st_nxt.snap = st_r.cfg;                                          // R14
    end
    st_nxt.pat    = st_nxt.snap.sstart[PAT_OFS_W-1:0];                 // R09
    st_nxt.fg_pix = blt_colour(st_nxt.snap.fg,                         // R10
                               st_nxt.snap.mode[blt_pkg::MODE_EXPW_LO +: 2], 1'b0);
    st_nxt.bg_pix = blt_colour(st_nxt.snap.bg,                         // R11
                               st_nxt.snap.mode[blt_pkg::MODE_EXPW_LO +: 2], 1'b1);
    st_nxt.dline  = blt_line_addr(st_r.snap.dstart, st_r.snap.dpitch, eng_line); // R14
    st_nxt.sline  = blt_line_addr(st_r.snap.sstart, st_r.snap.spitch, eng_line); // R14
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign host_rsp      = st_r.rsp;
  assign eng_params    = st_r.snap;
  assign eng_start     = st_r.start;
  assign eng_reset     = st_r.ctl[blt_pkg::ST_RESET];
  assign eng_autostart = st_r.ctl[blt_pkg::ST_AUTO];
  assign fg_pixel      = st_r.fg_pix;
  assign bg_pixel      = st_r.bg_pix;
  assign dst_line_addr = st_r.dline;
  assign src_line_addr = st_r.sline;
  assign pat_offset    = st_r.pat;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  logic wr_whi;
  logic wr_hhi;
  logic wr_dplo;
  logic wr_sphi;
  logic wr_ds2;
  logic wr_ss0;
  logic rd_whi;
  logic wr_go;
  assign wr_whi  = host_req.wr && ofs == blt_pkg::OFS_WHI;
  assign wr_hhi  = host_req.wr && ofs == blt_pkg::OFS_HHI;
  assign wr_dplo = host_req.wr && ofs == blt_pkg::OFS_DPLO;
  assign wr_sphi = host_req.wr && ofs == blt_pkg::OFS_SPHI;
  assign wr_ds2  = host_req.wr && ofs == blt_pkg::OFS_DS2;
  assign wr_ss0  = host_req.wr && ofs == blt_pkg::OFS_SS0;
  assign rd_whi  = host_req.rd && ofs == blt_pkg::OFS_WHI;
  assign wr_go   = go;

  property p_width_hi;
    @(posedge clk) disable iff (sys_rst)
    wr_whi |=> st_r.cfg.width[12:8] == $past(host_req.wdata[4:0]);
  endproperty
  a_width_hi: assert property (p_width_hi) else $error("width high byte not stored"); // R02

  property p_width_rd;
    @(posedge clk) disable iff (sys_rst)
    rd_whi |=> host_rsp.valid && host_rsp.data[7:5] == 3'h0
               && host_rsp.data[4:0] == st_r.cfg.width[12:8];
  endproperty
  a_width_rd: assert property (p_width_rd) else $error("width high byte read wrong"); // R01

  property p_height_hi;
    @(posedge clk) disable iff (sys_rst)
    wr_hhi |=> st_r.cfg.height == {$past(host_req.wdata[2:0]), $past(st_r.cfg.height[7:0])};
  endproperty
  a_height_hi: assert property (p_height_hi) else $error("height high byte not stored"); // R04

  property p_height_rd;
    @(posedge clk) disable iff (sys_rst)
    (host_req.rd && ofs == blt_pkg::OFS_HHI) |=> host_rsp.data[7:3] == 5'h0;
  endproperty
  a_height_rd: assert property (p_height_rd) else $error("height high bits not zero"); // R03

  property p_dpitch;
    @(posedge clk) disable iff (sys_rst)
    wr_dplo |=> st_r.cfg.dpitch[7:0] == $past(host_req.wdata)
                && st_r.cfg.dpitch[12:8] == $past(st_r.cfg.dpitch[12:8]);
  endproperty
  a_dpitch: assert property (p_dpitch) else $error("destination pitch low byte wrong"); // R05

  property p_spitch;
    @(posedge clk) disable iff (sys_rst)
    wr_sphi |=> st_r.cfg.spitch[12:8] == $past(host_req.wdata[4:0]);
  endproperty
  a_spitch: assert property (p_spitch) else $error("source pitch high byte wrong"); // R06

  property p_dstart;
    @(posedge clk) disable iff (sys_rst)
    wr_ds2 |=> st_r.cfg.dstart[21:16] == $past(host_req.wdata[5:0])
               && st_r.cfg.dstart[15:0] == $past(st_r.cfg.dstart[15:0]);
  endproperty
  a_dstart: assert property (p_dstart) else $error("destination start top byte wrong"); // R07

  property p_sstart;
    @(posedge clk) disable iff (sys_rst)
    wr_ss0 |=> st_r.cfg.sstart[7:0] == $past(host_req.wdata);
  endproperty
  a_sstart: assert property (p_sstart) else $error("source start low byte wrong"); // R08

  property p_pattern;
    @(posedge clk) disable iff (sys_rst)
    eng_start |-> pat_offset == eng_params.sstart[PAT_OFS_W-1:0];
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern offset mismatch"); // R09

  property p_colour8;
    @(posedge clk) disable iff (sys_rst)
    eng_params.mode[blt_pkg::MODE_EXPW_LO +: 2] == 2'h0
      |-> fg_pixel == {24'h0, eng_params.fg[7:0]} && bg_pixel == {24'h0, eng_params.bg[7:0]};
  endproperty
  a_colour8: assert property (p_colour8) else $error("8 bpp colour bytes wrong"); // R10

  property p_colour24;
    @(posedge clk) disable iff (sys_rst)
    eng_params.mode[blt_pkg::MODE_EXPW_LO +: 2] == 2'h2
      |-> fg_pixel == {8'h0, eng_params.fg[23:0]} && bg_pixel == 32'h0;
  endproperty
  a_colour24: assert property (p_colour24) else $error("24 bpp colour bytes wrong"); // R13

  property p_start;
    @(posedge clk) disable iff (sys_rst)
    wr_go |=> eng_start && eng_params.fg == $past(st_r.cfg.fg)
              && eng_params.bg == $past(st_r.cfg.bg) ##1 !eng_start;
  endproperty
  a_start: assert property (p_start) else $error("start snapshot wrong"); // R12

  property p_line;
    @(posedge clk) disable iff (sys_rst)
    !eng_start ##1 !eng_start |-> dst_line_addr ==
      22'({2'h0, $past(eng_params.dstart)} + 24'($past(eng_params.dpitch)) * 24'($past(eng_line)));
  endproperty
  a_line: assert property (p_line) else $error("destination line address wrong"); // R14

  property p_colour16;
    @(posedge clk) disable iff (sys_rst)
    eng_params.mode[blt_pkg::MODE_EXPW_LO +: 2] == 2'h1
      |-> fg_pixel == {16'h0, eng_params.fg[15:0]} && bg_pixel == {16'h0, eng_params.bg[15:0]};
  endproperty
  a_colour16: assert property (p_colour16) else $error("16 bpp colour bytes wrong"); // R10

  property p_colour32;
    @(posedge clk) disable iff (sys_rst)
    eng_params.mode[blt_pkg::MODE_EXPW_LO +: 2] == 2'h3
      |-> fg_pixel == eng_params.fg && bg_pixel == eng_params.bg;
  endproperty
  a_colour32: assert property (p_colour32) else $error("32 bpp colour bytes wrong"); // R10

  // Host writes between starts must never reach a running transfer
  property p_snap_hold;
    @(posedge clk) disable iff (sys_rst)
    !wr_go |=> eng_params == $past(eng_params);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved without start"); // R14

  property p_busy_drop;
    @(posedge clk) disable iff (sys_rst)
    eng_busy |=> !eng_start;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("start taken while busy"); // R14

endmodule : blt_param_regs

// [blt_param_regs_tb.sv]
// Self-checking bench for the block-transfer parameter bank
module blt_param_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   eng_busy = 1'b0;
  logic [10:0]            eng_line = 11'h000;
  blt_pkg::blt_host_req_t host_req;
  blt_pkg::blt_host_rsp_t host_rsp;
  blt_pkg::blt_params_t   eng_params;
  logic                   eng_start;
  logic                   eng_reset;
  logic                   eng_autostart;
  logic [31:0]            fg_pixel;
  logic [31:0]            bg_pixel;
  logic [21:0]            dst_line_addr;
  logic [21:0]            src_line_addr;
  logic [2:0]             pat_offset;
  logic [7:0]             regs [0:31];
  logic [7:0]             rdat;
  logic                   rval;
  logic [6:0]             o;
  logic [21:0]            ds;
  logic [21:0]            ss;
  logic [21:0]            dl;
  logic [21:0]            sl;
  int                     n_errors = 0;
  int                     comparisons = 0;

  initial forever #25 clk = ~clk;

  blt_host_model host_inst (.clk(clk), .host_req(host_req), .host_rsp(host_rsp));
  blt_param_regs #(.PAT_OFS_W(3)) blt_param_regs_inst (.clk(clk), .sys_rst(sys_rst),
    .host_req(host_req), .host_rsp(host_rsp), .eng_busy(eng_busy), .eng_line(eng_line),
    .eng_params(eng_params), .eng_start(eng_start), .eng_reset(eng_reset),
    .eng_autostart(eng_autostart), .fg_pixel(fg_pixel), .bg_pixel(bg_pixel),
    .dst_line_addr(dst_line_addr), .src_line_addr(src_line_addr), .pat_offset(pat_offset));

  // --------------------------------------------------------------
  // Expectation helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] fmask(input logic [6:0] a);
    case (a)
      7'h09, 7'h0D, 7'h0F: return 8'h1F;
      7'h0B:               return 8'h07;
      7'h12, 7'h16:        return 8'h3F;
      7'h13, 7'h19:        return 8'h00;
      default:             return 8'hFF;
    endcase
  endfunction : fmask
  // Index to offset; unmapped indices land on a hole that reads zero
  function automatic logic [6:0] ofs(input logic [6:0] i);
    if (i == 7'h00) return 7'h00;
    if (i == 7'h01) return 7'h04;
    if (i >= 7'h10 && i <= 7'h15) return {5'h00, i[2:1]} + (i[0] ? 7'h05 : 7'h01);
    if (i >= 7'h20 && i <= 7'h35) return i - 7'h18;
    return 7'h13;
  endfunction : ofs
  function automatic logic [31:0] pix(input logic [1:0] m, input logic [31:0] c, input logic bg);
    case (m)
      2'h0:    return {24'h000000, c[7:0]};
      2'h1:    return {16'h0000, c[15:0]};
      2'h2:    return bg ? 32'h00000000 : {8'h00, c[23:0]};
      default: return c;
    endcase
  endfunction : pix

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic io, input logic [6:0] a, input logic [7:0] e);
    host_inst.rd(io, a, rdat, rval);
    chk("read valid", 32'h00000001, {31'h0, rval});
    chk("read data", {24'h0, e}, {24'h0, rdat});
  endtask : rdchk
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h2355E99C));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 54; i++) begin
      if (i != 49) begin
        o = ofs(7'(i));
        rdat = 8'($urandom);
        regs[o] = rdat & fmask(o);
        host_inst.cyc(1'b1, 1'b1, 7'(i), rdat);
        rdchk(1'b0, o, regs[o]);
        rdchk(1'b1, 7'(i), regs[o]);
      end
    end
    host_inst.cyc(1'b1, 1'b0, 7'h7F, 8'hFF);
    eng_line <= 11'($urandom);
    rdchk(1'b0, 7'h7F, 8'h00);
    ds = {regs[18][5:0], regs[17], regs[16]};
    ss = {regs[22][5:0], regs[21], regs[20]};
    // Line addresses wrap within the 22-bit space
    dl = ds + 22'({regs[13][4:0], regs[12]}) * 22'(eng_line);
    sl = ss + 22'({regs[15][4:0], regs[14]}) * 22'(eng_line);
    for (int m = 0; m < 4; m++) begin
      regs[24] = {2'h0, 2'(m), 1'(m == 2), 3'h0};
      host_inst.cyc(1'b1, 1'b0, 7'h18, regs[24]);
      host_inst.cyc(1'b1, 1'b0, 7'h40, 8'h02);
      #1;
      chk("start", 1, eng_start);
      chk("width", {regs[9][4:0], regs[8]}, 32'(eng_params.width));
      chk("height", {regs[11][2:0], regs[10]}, 32'(eng_params.height));
      chk("dpitch", {regs[13][4:0], regs[12]}, 32'(eng_params.dpitch));
      chk("spitch", {regs[15][4:0], regs[14]}, 32'(eng_params.spitch));
      chk("dstart", 32'(ds), 32'(eng_params.dstart));
      chk("sstart", 32'(ss), 32'(eng_params.sstart));
      chk("pattern", 32'(ss[2:0]), 32'(pat_offset));
      chk("fg", pix(2'(m), {regs[7], regs[6], regs[5], regs[4]}, 1'b0), fg_pixel);
      chk("bg", pix(2'(m), {regs[3], regs[2], regs[1], regs[0]}, 1'b1), bg_pixel);
      chk("clip mode", 32'({regs[23], regs[24]}), 32'({eng_params.clip, eng_params.mode}));
      chk("rop", 32'({regs[26], regs[27]}), 32'({eng_params.rop, eng_params.mode_ext}));
      chk("key", 32'({regs[29], regs[28]}), 32'(eng_params.key));
      @(posedge clk);
      #1;
      chk("start end", 0, eng_start);
      chk("dline", 32'(dl), 32'(dst_line_addr));
      chk("sline", 32'(sl), 32'(src_line_addr));
    end
    host_inst.cyc(1'b1, 1'b0, 7'h08, ~regs[8]);
    eng_busy <= 1'b1;
    #1;
    chk("held width", {regs[9][4:0], regs[8]}, 32'(eng_params.width));
    host_inst.cyc(1'b1, 1'b0, 7'h40, 8'hE6);
    #1;
    chk("busy start", 0, eng_start);
    chk("eng reset", 1, eng_reset);
    chk("autostart", 1, eng_autostart);
    rdchk(1'b1, 7'h31, 8'hE5);
    host_inst.cyc(1'b1, 1'b0, 7'h40, 8'h00);
    eng_busy <= 1'b0;
    rdchk(1'b0, 7'h40, 8'h00);
    tally_and_finish();
  end
endmodule : blt_param_regs_tb

// [blt_pkg.sv]
// Shared constants and carrier types for the block-transfer parameter bank
package blt_pkg;

  // ---------------------------------------------------------------------------
  // Field widths
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned WIDTH_W  = 13;
  localparam int unsigned HEIGHT_W = 11;
  localparam int unsigned PITCH_W  = 13;
  localparam int unsigned START_W  = 22;

  // ---------------------------------------------------------------------------
  // Memory-mapped byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [6:0] OFS_BG0   = 7'h00;
  localparam logic [6:0] OFS_BG1   = 7'h01;
  localparam logic [6:0] OFS_BG2   = 7'h02;
  localparam logic [6:0] OFS_BG3   = 7'h03;
  localparam logic [6:0] OFS_FG0   = 7'h04;
  localparam logic [6:0] OFS_FG1   = 7'h05;
  localparam logic [6:0] OFS_FG2   = 7'h06;
  localparam logic [6:0] OFS_FG3   = 7'h07;
  localparam logic [6:0] OFS_WLO   = 7'h08;
  localparam logic [6:0] OFS_WHI   = 7'h09;
  localparam logic [6:0] OFS_HLO   = 7'h0A;
  localparam logic [6:0] OFS_HHI   = 7'h0B;
  localparam logic [6:0] OFS_DPLO  = 7'h0C;
  localparam logic [6:0] OFS_DPHI  = 7'h0D;
  localparam logic [6:0] OFS_SPLO  = 7'h0E;
  localparam logic [6:0] OFS_SPHI  = 7'h0F;
  localparam logic [6:0] OFS_DS0   = 7'h10;
  localparam logic [6:0] OFS_DS1   = 7'h11;
  localparam logic [6:0] OFS_DS2   = 7'h12;
  localparam logic [6:0] OFS_SS0   = 7'h14;
  localparam logic [6:0] OFS_SS1   = 7'h15;
  localparam logic [6:0] OFS_SS2   = 7'h16;
  localparam logic [6:0] OFS_CLIP  = 7'h17;
  localparam logic [6:0] OFS_MODE  = 7'h18;
  localparam logic [6:0] OFS_ROP   = 7'h1A;
  localparam logic [6:0] OFS_MEXT  = 7'h1B;
  localparam logic [6:0] OFS_KEY0  = 7'h1C;
  localparam logic [6:0] OFS_KEY1  = 7'h1D;
  localparam logic [6:0] OFS_START = 7'h40;
  localparam logic [6:0] OFS_NONE  = 7'h7F;

  // ---------------------------------------------------------------------------
  // Indexed port: indices that differ from the offsets above
  // ---------------------------------------------------------------------------
  localparam logic [6:0] IDX_BG0   = 7'h00;
  localparam logic [6:0] IDX_FG0   = 7'h01;
  localparam logic [6:0] IDX_COL1  = 7'h10;
  localparam logic [6:0] IDX_COL7  = 7'h15;
  localparam logic [6:0] IDX_FIRST = 7'h20;
  localparam logic [6:0] IDX_LAST  = 7'h35;
  localparam logic [6:0] IDX_START = 7'h31;
  localparam logic [6:0] IDX_BASE  = 7'h18;

  // ---------------------------------------------------------------------------
  // Mode and start/status bit positions, reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned MODE_EXPW_LO = 4;
  localparam int unsigned ST_AUTO      = 7;
  localparam int unsigned ST_SYSLOC    = 6;
  localparam int unsigned ST_PAUSE     = 5;
  localparam int unsigned ST_RESET     = 2;
  localparam int unsigned ST_START     = 1;
  localparam int unsigned ST_BUSY      = 0;
  localparam logic [7:0]  ST_WR_MASK   = 8'hE4;
  localparam logic [7:0]  RST_BYTE     = 8'h00;

  typedef enum logic [1:0] {
    BPP8  = 2'h0,
    BPP16 = 2'h1,
    BPP24 = 2'h2,
    BPP32 = 2'h3
  } blt_bpp_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              io;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } blt_host_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } blt_host_rsp_t;

  typedef struct packed {
    logic [31:0]         bg;
    logic [31:0]         fg;
    logic [WIDTH_W-1:0]  width;
    logic [HEIGHT_W-1:0] height;
    logic [PITCH_W-1:0]  dpitch;
    logic [PITCH_W-1:0]  spitch;
    logic [START_W-1:0]  dstart;
    logic [START_W-1:0]  sstart;
    logic [7:0]          clip;
    logic [7:0]          mode;
    logic [7:0]          rop;
    logic [7:0]          mode_ext;
    logic [15:0]         key;
  } blt_params_t;

endpackage : blt_pkg
